//--- inc/rtc_bus_if.sv
// parallel bus and interrupt line between timekeeper and host
`timescale 1ns/100ps
interface rtc_bus_if;
	logic cs_n;
	logic wr_n;
	logic rd_n;
	logic [3:0] addr;
	logic [3:0] host_data;
	logic host_data_oe;
	logic [3:0] dev_data;
	logic dev_data_oe;
	logic [3:0] data;
	logic int_drv;
	logic int_oe;
	logic int_n;

	// undriven data bus and interrupt line float high through pull-ups
	assign data = dev_data_oe ? dev_data : (host_data_oe ? host_data : 4'hF);
	assign int_n = int_oe ? int_drv : 1'b1;

	modport device(input cs_n, input wr_n, input rd_n, input addr, input data,
		output dev_data, output dev_data_oe, output int_drv, output int_oe);
	modport host(output cs_n, output wr_n, output rd_n, output addr, output host_data,
		output host_data_oe, input data, input int_n);
endinterface

//--- inc/rtc_pkg.sv
// constants shared by the timekeeper device end and the bus host end
// Operation
// - device latches write on strobe trailing edge
// - write strobe: chip select and write low
// - read strobe: chip select and read low
// - host control reads shorter than 30 ms
// - every counter its own 4-bit addressable word
// - counters presented as BCD digits
// - unused bits of narrow registers read zero
// - writes to unused bits are discarded
// - halt clears divider and tenths, holds them
// - release resumes timing on whole second
// - all counters advance together every 100 ms
// - host rereads time when data-changed is set
// - interrupt delays 0.1-60 s, single or repeat
// - interrupt pin pulled low on timeout
// - control register read releases the interrupt
// - test mode puts oscillator on interrupt pin
// - data-changed at bit 3, read clears
// - run-halt at bit 2 of control
package rtc_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLOCK_HZ = 20_000_000;
	localparam int unsigned CLOCK_MHZ = CLOCK_HZ / 1_000_000;
	localparam int unsigned UPDATE_MS = 100;
	localparam int unsigned UPDATE_CYCLES = CLOCK_HZ / 1000 * UPDATE_MS;
	localparam int unsigned OSC_HZ = 32768;
	localparam int unsigned OSC_HALF_CYCLES = CLOCK_HZ / (2 * OSC_HZ);
	localparam int unsigned SETUP_NS = 50;
	localparam int unsigned STROBE_NS = 650;
	localparam int unsigned SETUP_CYCLES = (SETUP_NS * CLOCK_MHZ + 999) / 1000;
	localparam int unsigned STROBE_CYCLES = (STROBE_NS * CLOCK_MHZ + 999) / 1000;
	localparam int unsigned CTRL_READ_MAX_MS = 30;

	// ----------------------------------------------------------------
	// device register map
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_TENTHS = 4'h1;
	localparam logic [3:0] ADDR_SEC_U = 4'h2;
	localparam logic [3:0] ADDR_SEC_T = 4'h3;
	localparam logic [3:0] ADDR_MIN_U = 4'h4;
	localparam logic [3:0] ADDR_MIN_T = 4'h5;
	localparam logic [3:0] ADDR_HOUR_U = 4'h6;
	localparam logic [3:0] ADDR_HOUR_T = 4'h7;
	localparam logic [3:0] ADDR_DAY_U = 4'h8;
	localparam logic [3:0] ADDR_DAY_T = 4'h9;
	localparam logic [3:0] ADDR_MON_U = 4'hA;
	localparam logic [3:0] ADDR_MON_T = 4'hB;
	localparam logic [3:0] ADDR_YEAR_U = 4'hC;
	localparam logic [3:0] ADDR_YEAR_T = 4'hD;
	localparam logic [3:0] ADDR_WEEKDAY = 4'hE;
	localparam logic [3:0] ADDR_SETTING = 4'hF;

	// control: write view and read view share address 0
	localparam int unsigned CTRL_SEL_BIT = 0;
	localparam int unsigned CTRL_FLAG_BIT = 0;
	localparam int unsigned CTRL_HALT_BIT = 2;
	localparam int unsigned CTRL_TEST_BIT = 3;
	localparam int unsigned CTRL_CHANGED_BIT = 3;
	// interrupt register: delay code and repeat bit
	localparam int unsigned IRQ_REPEAT_BIT = 3;
	localparam int unsigned IRQ_CODE_LSB = 0;
	localparam int unsigned IRQ_CODE_W = 3;
	// clock setting register
	localparam int unsigned SET_PM_BIT = 1;
	localparam int unsigned SET_LEAP_LSB = 2;
	localparam int unsigned SET_LEAP_W = 2;

	// writable bits per address, low nibble is address 0
	localparam logic [15:0][3:0] WRITE_MASKS = 64'hF7FF_1F3F_1F7F_7F0F;
	// reset: 12:00 AM, day 1, month 1, weekday 1
	localparam logic [15:0][3:0] RESET_DIGITS = 64'h0100_0101_1200_0000;

	// delays in 100 ms updates for codes 1..7, code 0 is off
	localparam logic [7:0][9:0] DELAY_TENTHS = {10'h258, 10'h12C, 10'h064, 10'h032,
		10'h00A, 10'h005, 10'h001, 10'h000};

	// ----------------------------------------------------------------
	// calendar limits
	// ----------------------------------------------------------------
	localparam int unsigned BCD_BASE = 10;
	localparam logic [3:0] DIGIT_MAX = 4'h9;
	localparam logic [6:0] SEC_MAX = 7'h3B;
	localparam logic [6:0] HOUR_ELEVEN = 7'h0B;
	localparam logic [6:0] HOUR_TWELVE = 7'h0C;
	localparam logic [6:0] ONE = 7'h01;
	localparam logic [6:0] ZERO = 7'h00;
	localparam logic [6:0] WEEK_DAYS = 7'h07;
	localparam logic [6:0] MONTHS = 7'h0C;
	localparam logic [6:0] YEAR_MAX = 7'h63;
	localparam logic [6:0] FEBRUARY = 7'h02;
	localparam logic [6:0] APRIL = 7'h04;
	localparam logic [6:0] JUNE = 7'h06;
	localparam logic [6:0] SEPTEMBER = 7'h09;
	localparam logic [6:0] NOVEMBER = 7'h0B;
	localparam logic [6:0] DAYS_28 = 7'h1C;
	localparam logic [6:0] DAYS_29 = 7'h1D;
	localparam logic [6:0] DAYS_30 = 7'h1E;
	localparam logic [6:0] DAYS_31 = 7'h1F;

	// ----------------------------------------------------------------
	// host controller registers, Avalon byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] HOST_CMD = 8'h00;
	localparam logic [7:0] HOST_STATUS = 8'h04;
	localparam logic [7:0] HOST_IRQ_STATUS = 8'h08;
	localparam logic [7:0] HOST_IRQ_CLEAR = 8'h0C;
	localparam logic [7:0] HOST_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] HOST_SNAP_LO = 8'h14;
	localparam logic [7:0] HOST_SNAP_HI = 8'h18;
	localparam int unsigned CMD_DATA_LSB = 0;
	localparam int unsigned CMD_ADDR_LSB = 4;
	localparam int unsigned CMD_READ_BIT = 8;
	localparam int unsigned CMD_SCAN_BIT = 9;
	localparam int unsigned ST_BUSY_BIT = 0;
	localparam int unsigned ST_LAST_LSB = 4;
	localparam int unsigned ST_INT_BIT = 8;
	localparam int unsigned IRQ_W = 2;
	localparam int unsigned EV_DONE_BIT = 0;
	localparam int unsigned EV_PIN_BIT = 1;

	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_SETUP = 3'h1,
		H_STROBE = 3'h3,
		H_HOLD = 3'h2
	} host_phase_t;

endpackage

//--- src/rtc_device.sv
// timekeeper device end: BCD counters, control, interrupt timer, bus access
//
// Chosen here: the address map and register access over the parallel chip-select bus.
`timescale 1ns/100ps
module rtc_device #(
	parameter int unsigned UPDATE_CYCLES_P = rtc_pkg::UPDATE_CYCLES
) (
	input wire logic CLOCK_IN,
	input wire logic RESET_N_IN,
	rtc_bus_if.device BUS,
	output logic UPDATE_OUT
);
	import rtc_pkg::*;

	typedef struct packed {
		logic [15:0][3:0] dig;
		logic [3:0] irq_cfg;
		logic sel;
		logic halt;
		logic test;
		logic changed;
		logic flag;
		logic [31:0] div;
		logic [9:0] irq_cnt;
		logic irq_run;
		logic [15:0] osc_cnt;
		logic osc;
		logic ws;
		logic rs;
		logic rd_ctrl;
		logic [3:0] wa;
		logic [3:0] wd;
		logic [3:0] rdata;
		logic rd_oe;
		logic int_oe;
		logic upd;
	} dev_state_t;

	dev_state_t s_q;
	dev_state_t s_d;
	logic combined_store_strobe;
	logic combined_fetch_strobe;

	// ----------------------------------------------------------------
	// BCD helpers
	// ----------------------------------------------------------------
	function automatic logic [6:0] pair_val(input logic [3:0] t, input logic [3:0] u);
		return 7'({3'h0, t} * BCD_BASE + {3'h0, u});
	endfunction

	function automatic logic [7:0] pair_bcd(input logic [6:0] v);
		return {4'(v / BCD_BASE), 4'(v % BCD_BASE)};
	endfunction

	// returns {carry, tens, units}; out-of-range values fall back to lo
	function automatic logic [8:0] bcd_step(input logic [3:0] t, input logic [3:0] u,
		input logic [6:0] lo, input logic [6:0] hi);
		logic [6:0] v;
		v = pair_val(t, u);
		if (v >= hi) begin
			return {1'b1, pair_bcd(lo)};
		end
		return {1'b0, pair_bcd(7'(v + ONE))};
	endfunction

	function automatic logic [6:0] month_days(input logic [6:0] m, input logic [1:0] leap);
		if (m == FEBRUARY) begin
			return (leap == 2'h0) ? DAYS_29 : DAYS_28;
		end
		if (m == APRIL || m == JUNE || m == SEPTEMBER || m == NOVEMBER) begin
			return DAYS_30;
		end
		return DAYS_31;
	endfunction

	function automatic logic [9:0] delay_of(input logic [3:0] cfg);
		return DELAY_TENTHS[cfg[IRQ_CODE_LSB +: IRQ_CODE_W]];
	endfunction

	// one 100 ms step of every counter from the same old snapshot
	function automatic logic [15:0][3:0] advance(input logic [15:0][3:0] d);
		logic [15:0][3:0] r;
		logic [8:0] st;
		logic [6:0] h;
		logic c;
		r = d;
		c = 1'b0;
		if (d[ADDR_TENTHS] >= DIGIT_MAX) begin
			r[ADDR_TENTHS] = 4'h0;
			c = 1'b1;
		end else begin
			r[ADDR_TENTHS] = 4'(d[ADDR_TENTHS] + 4'h1);
		end
		if (c) begin
			st = bcd_step(d[ADDR_SEC_T], d[ADDR_SEC_U], ZERO, SEC_MAX);
			{c, r[ADDR_SEC_T], r[ADDR_SEC_U]} = st;
		end
		if (c) begin
			st = bcd_step(d[ADDR_MIN_T], d[ADDR_MIN_U], ZERO, SEC_MAX);
			{c, r[ADDR_MIN_T], r[ADDR_MIN_U]} = st;
		end
		if (c) begin
			h = pair_val(d[ADDR_HOUR_T], d[ADDR_HOUR_U]);
			if (h == HOUR_ELEVEN) begin
				// PM to AM at midnight carries into the date
				c = d[ADDR_SETTING][SET_PM_BIT];
				r[ADDR_SETTING][SET_PM_BIT] = ~d[ADDR_SETTING][SET_PM_BIT];
				{r[ADDR_HOUR_T], r[ADDR_HOUR_U]} = pair_bcd(HOUR_TWELVE);
			end else begin
				c = 1'b0;
				st = bcd_step(d[ADDR_HOUR_T], d[ADDR_HOUR_U], ONE, HOUR_TWELVE);
				{r[ADDR_HOUR_T], r[ADDR_HOUR_U]} = st[7:0];
			end
		end
		if (c) begin
			if (pair_val(4'h0, d[ADDR_WEEKDAY]) >= WEEK_DAYS) begin
				r[ADDR_WEEKDAY] = 4'h1;
			end else begin
				r[ADDR_WEEKDAY] = 4'(d[ADDR_WEEKDAY] + 4'h1);
			end
			st = bcd_step(d[ADDR_DAY_T], d[ADDR_DAY_U], ONE,
				month_days(pair_val(d[ADDR_MON_T], d[ADDR_MON_U]),
				d[ADDR_SETTING][SET_LEAP_LSB +: SET_LEAP_W]));
			{c, r[ADDR_DAY_T], r[ADDR_DAY_U]} = st;
		end
		if (c) begin
			st = bcd_step(d[ADDR_MON_T], d[ADDR_MON_U], ONE, MONTHS);
			{c, r[ADDR_MON_T], r[ADDR_MON_U]} = st;
		end
		if (c) begin
			r[ADDR_SETTING][SET_LEAP_LSB +: SET_LEAP_W] =
				2'(d[ADDR_SETTING][SET_LEAP_LSB +: SET_LEAP_W] + 2'h1);
			st = bcd_step(d[ADDR_YEAR_T], d[ADDR_YEAR_U], ZERO, YEAR_MAX);
			{r[ADDR_YEAR_T], r[ADDR_YEAR_U]} = st[7:0];
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// strobes
	// ----------------------------------------------------------------
	assign combined_store_strobe = !BUS.cs_n && !BUS.wr_n;
	assign combined_fetch_strobe = !BUS.cs_n && !BUS.rd_n;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.upd = 1'b0;
		s_d.ws = combined_store_strobe;
		s_d.rs = combined_fetch_strobe;

		// free-running stand-in for the crystal, only seen in test mode
		if (s_q.osc_cnt >= 16'(OSC_HALF_CYCLES - 1)) begin
			s_d.osc_cnt = 16'h0;
			s_d.osc = ~s_q.osc;
		end else begin
			s_d.osc_cnt = 16'(s_q.osc_cnt + 16'h1);
		end

		if (s_q.halt) begin
			s_d.div = 32'h0;
			s_d.dig[ADDR_TENTHS] = 4'h0;
		end else if (s_q.div >= 32'(UPDATE_CYCLES_P - 1)) begin
			s_d.div = 32'h0;
			s_d.upd = 1'b1;
			s_d.dig = advance(s_q.dig);
		end else begin
			s_d.div = 32'(s_q.div + 32'h1);
		end

		// interrupt timer counts updates while armed
		if (s_d.upd && s_q.irq_run) begin
			if (s_q.irq_cnt <= 10'h1) begin
				s_d.flag = 1'b1;
				if (s_q.irq_cfg[IRQ_REPEAT_BIT]) begin
					s_d.irq_cnt = delay_of(s_q.irq_cfg);
				end else begin
					s_d.irq_run = 1'b0;
				end
			end else begin
				s_d.irq_cnt = 10'(s_q.irq_cnt - 10'h1);
			end
		end

		// address and data are sampled while the store strobe is low
		if (combined_store_strobe) begin
			s_d.wa = BUS.addr;
			s_d.wd = BUS.data;
		end
		if (s_q.ws && !combined_store_strobe) begin
			if (s_q.wa == ADDR_CTRL) begin
				s_d.sel = s_q.wd[CTRL_SEL_BIT];
				s_d.halt = s_q.wd[CTRL_HALT_BIT];
				s_d.test = s_q.wd[CTRL_TEST_BIT];
			end else if (s_q.wa == ADDR_SETTING && s_q.sel) begin
				s_d.irq_cfg = s_q.wd;
				s_d.irq_cnt = delay_of(s_q.wd);
				s_d.irq_run = (delay_of(s_q.wd) != 10'h0);
			end else if (s_q.wa != ADDR_TENTHS) begin
				s_d.dig[s_q.wa] = s_q.wd & WRITE_MASKS[s_q.wa];
			end
		end

		// read data and its enable are registered, so the bus is driven one cycle behind the fetch strobe
		s_d.rd_oe = combined_fetch_strobe;
		s_d.rdata = 4'h0;
		if (BUS.addr == ADDR_CTRL) begin
			s_d.rdata[CTRL_CHANGED_BIT] = s_q.changed;
			s_d.rdata[CTRL_HALT_BIT] = s_q.halt;
			s_d.rdata[CTRL_FLAG_BIT] = s_q.flag;
		end else if (BUS.addr == ADDR_SETTING && s_q.sel) begin
			s_d.rdata = s_q.irq_cfg;
		end else begin
			s_d.rdata = s_q.dig[BUS.addr] & WRITE_MASKS[BUS.addr];
		end
		if (ADDR_TENTHS == BUS.addr) begin
			s_d.rdata = s_q.dig[ADDR_TENTHS];
		end

		// clear at the end of a control read, so the value read stays stable
		if (combined_fetch_strobe) begin
			s_d.rd_ctrl = (BUS.addr == ADDR_CTRL);
		end
		if (s_q.rs && !combined_fetch_strobe && s_q.rd_ctrl) begin
			s_d.changed = 1'b0;
			s_d.flag = 1'b0;
			s_d.rd_ctrl = 1'b0;
		end
		// a timeout or update in the clearing cycle still sets its flag
		if (s_d.upd) begin
			s_d.changed = 1'b1;
		end
		if (s_d.upd && s_q.irq_run && s_q.irq_cnt <= 10'h1) begin
			s_d.flag = 1'b1;
		end

		// open drain: pull low on flag, or follow the oscillator in test mode
		s_d.int_oe = s_d.test ? ~s_d.osc : s_d.flag;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			s_q <= '0;
			s_q.dig <= RESET_DIGITS;
		end else begin
			s_q <= s_d;
		end
	end

	assign BUS.dev_data = s_q.rdata;
	assign BUS.dev_data_oe = s_q.rd_oe;
	assign BUS.int_drv = 1'b0;
	assign BUS.int_oe = s_q.int_oe;
	assign UPDATE_OUT = s_q.upd;

endmodule // rtc_device

//--- src/rtc_host.sv
// host end: Avalon-MM command registers driving the timekeeper bus
`timescale 1ns/100ps
module rtc_host (
	input wire logic CLOCK_IN,
	input wire logic RESET_N_IN,
	input wire logic [7:0] ADDRESS_IN,
	input wire logic READ_IN,
	input wire logic WRITE_IN,
	input wire logic [31:0] WRITEDATA_IN,
	output logic [31:0] READDATA_OUT,
	output logic WAITREQUEST_OUT,
	output logic IRQ_OUT,
	rtc_bus_if.host BUS
);
	import rtc_pkg::*;

	typedef struct packed {
		rtc_pkg::host_phase_t phase;
		logic [7:0] cnt;
		logic [3:0] addr;
		logic [3:0] wdata;
		logic is_read;
		logic scan;
		logic [15:0][3:0] snap;
		logic [3:0] last;
		logic cs_n;
		logic wr_n;
		logic rd_n;
		logic data_oe;
		logic pin_q;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_en;
		logic waitreq;
		logic [31:0] readdata;
		logic irq;
	} host_state_t;

	host_state_t s_q;
	host_state_t s_d;
	logic [IRQ_W-1:0] ev;
	logic busy;

	assign busy = (s_q.phase != H_IDLE);

	always_comb begin
		s_d = s_q;
		ev = '0;
		s_d.pin_q = BUS.int_n;
		ev[EV_PIN_BIT] = s_q.pin_q && !BUS.int_n;

		// ------------------------------------------------------------
		// access sequencer
		// ------------------------------------------------------------
		case (s_q.phase)
			H_IDLE: begin
				s_d.cnt = 8'h0;
			end
			H_SETUP: begin
				if (s_q.cnt >= 8'(SETUP_CYCLES - 1)) begin
					s_d.phase = H_STROBE;
					s_d.cnt = 8'h0;
				end else begin
					s_d.cnt = 8'(s_q.cnt + 8'h1);
				end
			end
			H_STROBE: begin
				// fixed strobe far below the control read limit
				if (s_q.cnt >= 8'(STROBE_CYCLES - 1)) begin
					s_d.phase = H_HOLD;
					s_d.cnt = 8'h0;
					if (s_q.is_read) begin
						s_d.last = BUS.data;
						s_d.snap[s_q.addr] = BUS.data;
					end
				end else begin
					s_d.cnt = 8'(s_q.cnt + 8'h1);
				end
			end
			H_HOLD: begin
				s_d.phase = H_IDLE;
				if (s_q.scan) begin
					s_d.phase = H_SETUP;
					if (s_q.addr == ADDR_CTRL) begin
						if (s_q.last[CTRL_CHANGED_BIT]) begin
							s_d.addr = ADDR_TENTHS;
						end else begin
							s_d.phase = H_IDLE;
						end
					end else if (s_q.addr == ADDR_WEEKDAY) begin
						s_d.addr = ADDR_CTRL;
					end else begin
						s_d.addr = 4'(s_q.addr + 4'h1);
					end
				end
				ev[EV_DONE_BIT] = (s_d.phase == H_IDLE);
			end
			default: begin
				s_d.phase = H_IDLE;
			end
		endcase

		// ------------------------------------------------------------
		// Avalon slave, one cycle answer; a command waits while busy
		// ------------------------------------------------------------
		s_d.waitreq = 1'b1;
		if (s_q.waitreq && (READ_IN || WRITE_IN)
			&& !(WRITE_IN && ADDRESS_IN == HOST_CMD && busy)) begin
			s_d.waitreq = 1'b0;
			s_d.readdata = 32'h0;
			if (WRITE_IN) begin
				case (ADDRESS_IN)
					HOST_CMD: begin
						s_d.phase = H_SETUP;
						s_d.cnt = 8'h0;
						s_d.scan = WRITEDATA_IN[CMD_SCAN_BIT];
						s_d.is_read = WRITEDATA_IN[CMD_READ_BIT] || WRITEDATA_IN[CMD_SCAN_BIT];
						s_d.addr = WRITEDATA_IN[CMD_SCAN_BIT] ? ADDR_TENTHS
							: WRITEDATA_IN[CMD_ADDR_LSB +: 4];
						s_d.wdata = WRITEDATA_IN[CMD_DATA_LSB +: 4];
					end
					HOST_IRQ_CLEAR: begin
						s_d.irq_st = s_q.irq_st & ~WRITEDATA_IN[IRQ_W-1:0];
					end
					HOST_IRQ_ENABLE: begin
						s_d.irq_en = WRITEDATA_IN[IRQ_W-1:0];
					end
					default: begin
					end
				endcase
			end else begin
				case (ADDRESS_IN)
					HOST_STATUS: begin
						s_d.readdata[ST_BUSY_BIT] = busy;
						s_d.readdata[ST_LAST_LSB +: 4] = s_q.last;
						s_d.readdata[ST_INT_BIT] = !BUS.int_n;
					end
					HOST_IRQ_STATUS: s_d.readdata = 32'(s_q.irq_st);
					HOST_IRQ_ENABLE: s_d.readdata = 32'(s_q.irq_en);
					HOST_SNAP_LO: s_d.readdata = s_q.snap[8:1];
					HOST_SNAP_HI: s_d.readdata = 32'(s_q.snap[14:9]);
					default: s_d.readdata = 32'h0;
				endcase
			end
		end
		// events win over a clear in the same cycle
		s_d.irq_st = s_d.irq_st | ev;
		s_d.irq = |(s_d.irq_st & s_d.irq_en);

		// pins follow the next phase so they come straight from flops
		s_d.cs_n = (s_d.phase == H_IDLE);
		s_d.wr_n = !(s_d.phase == H_STROBE && !s_d.is_read);
		s_d.rd_n = !(s_d.phase == H_STROBE && s_d.is_read);
		s_d.data_oe = (s_d.phase != H_IDLE) && !s_d.is_read;
	end

	always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			s_q <= '0;
			s_q.cs_n <= 1'b1;
			s_q.wr_n <= 1'b1;
			s_q.rd_n <= 1'b1;
			s_q.pin_q <= 1'b1;
			s_q.waitreq <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign READDATA_OUT = s_q.readdata;
	assign WAITREQUEST_OUT = s_q.waitreq;
	assign IRQ_OUT = s_q.irq;
	assign BUS.cs_n = s_q.cs_n;
	assign BUS.wr_n = s_q.wr_n;
	assign BUS.rd_n = s_q.rd_n;
	assign BUS.addr = s_q.addr;
	assign BUS.host_data = s_q.wdata;
	assign BUS.host_data_oe = s_q.data_oe;

endmodule // rtc_host

//--- tb/bcd_timekeeper_bus_clock_tb.sv
// testbench: Avalon commands through the host end to the timekeeper end
`timescale 1ns/100ps
`define CHK(name, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
	$display("unexpected %s expected %0h seen %0h", name, exp, got); end end
module bcd_timekeeper_bus_clock_tb;
	import rtc_pkg::*;
	// short update period so the longest delay code fits in the run
	localparam int UPD = 20;
	logic clock, reset_n, av_read, av_write, av_wait, irq, update, p;
	logic [7:0] av_address;
	logic [31:0] av_wdata, av_rdata, r;
	logic [3:0] v;
	logic [1:0] seen;
	int n_fail = 0;
	int checks_done = 0;
	int n;

	rtc_bus_if bus_if();
	rtc_device #(.UPDATE_CYCLES_P(UPD)) rtc_device_inst (.CLOCK_IN(clock),
		.RESET_N_IN(reset_n), .BUS(bus_if.device), .UPDATE_OUT(update));
	rtc_host rtc_host_inst (.CLOCK_IN(clock), .RESET_N_IN(reset_n), .ADDRESS_IN(av_address),
		.READ_IN(av_read), .WRITE_IN(av_write), .WRITEDATA_IN(av_wdata),
		.READDATA_OUT(av_rdata), .WAITREQUEST_OUT(av_wait), .IRQ_OUT(irq), .BUS(bus_if.host));
	rtc_bus_properties rtc_bus_properties_inst (.CLOCK_IN(clock), .RESET_N_IN(reset_n),
		.cs_n(bus_if.cs_n), .wr_n(bus_if.wr_n), .rd_n(bus_if.rd_n), .addr(bus_if.addr),
		.data(bus_if.data), .dev_data_oe(bus_if.dev_data_oe), .int_oe(bus_if.int_oe));

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		av_address <= a;
		av_wdata <= d;
		av_write <= 1'b1;
		do @(posedge clock); while (av_wait !== 1'b0);
		av_write <= 1'b0;
		@(posedge clock);
	endtask

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		av_address <= a;
		av_read <= 1'b1;
		do @(posedge clock); while (av_wait !== 1'b0);
		d = av_rdata;
		av_read <= 1'b0;
		@(posedge clock);
	endtask

	task automatic dev_idle(output logic [31:0] s);
		do bus_rd(HOST_STATUS, s); while (s[ST_BUSY_BIT] !== 1'b0);
	endtask

	task automatic dev_wr(input logic [3:0] a, input logic [3:0] d);
		logic [31:0] s;
		bus_wr(HOST_CMD, {22'h0, 2'b00, a, d});
		dev_idle(s);
	endtask

	task automatic dev_rd(input logic [3:0] a, output logic [3:0] d);
		logic [31:0] s;
		bus_wr(HOST_CMD, {22'h0, 2'b01, a, 4'h0});
		dev_idle(s);
		d = s[7:4];
	endtask

	task automatic pin_rd(output logic q);
		logic [31:0] s;
		bus_rd(HOST_STATUS, s);
		q = s[ST_INT_BIT];
	endtask

	task automatic tally_and_finish;
		if (n_fail == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// clock, watchdog and tests
	// ----------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	initial begin
		repeat (90000) @(posedge clock);
		n_fail++;
		tally_and_finish;
	end

	initial begin
		reset_n = 1'b0;
		av_read = 1'b0;
		av_write = 1'b0;
		av_address = 8'h00;
		av_wdata = 32'h0;
		repeat (6) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		dev_rd(ADDR_WEEKDAY, v);
		`CHK("weekday", 4'h1, v)
		bus_rd(8'h40, r);
		`CHK("unmapped", 32'h0, r)
		// halt, then load every counter with its unused bits set
		dev_wr(ADDR_CTRL, 4'h4);
		dev_rd(ADDR_CTRL, v);
		dev_rd(ADDR_CTRL, v);
		`CHK("halt bit", 1'b1, v[2])
		`CHK("changed cleared", 1'b0, v[3])
		dev_wr(ADDR_TENTHS, 4'h7);
		for (int a = 2; a < 15; a++) dev_wr(a[3:0], ~WRITE_MASKS[a] | 4'h1);
		for (int a = 1; a < 15; a++) begin
			dev_rd(a[3:0], v);
			`CHK("counter", (a == 1) ? 4'h0 : 4'h1, v)
		end
		// run across a minute carry, then halt to read a still picture
		dev_wr(ADDR_SEC_T, 4'h5);
		dev_wr(ADDR_SEC_U, 4'h9);
		dev_wr(ADDR_CTRL, 4'h0);
		repeat (15 * UPD) @(posedge clock);
		dev_wr(ADDR_CTRL, 4'h4);
		dev_rd(ADDR_CTRL, v);
		`CHK("changed set", 1'b1, v[3])
		dev_rd(ADDR_SEC_T, v);
		`CHK("seconds tens", 4'h0, v)
		dev_rd(ADDR_MIN_U, v);
		`CHK("minutes units", 4'h2, v)
		dev_rd(ADDR_SEC_U, v);
		`CHK("seconds units small", 1'b1, v <= 4'h2)
		// scan while halted: nothing changes, so one pass ends it
		bus_wr(HOST_CMD, 32'h200);
		dev_idle(r);
		bus_rd(HOST_SNAP_HI, r);
		`CHK("snapshot high", 32'h0011_1111, r)
		bus_rd(HOST_SNAP_LO, r);
		`CHK("snapshot low", 32'h1111_2000, r & 32'hFFFF_FF0F)
		// every delay code, single shot
		dev_wr(ADDR_CTRL, 4'h1);
		for (int c = 1; c < 8; c++) begin
			n = DELAY_TENTHS[c] * UPD;
			dev_wr(ADDR_SETTING, c[3:0]);
			if (c > 2) begin
				repeat (n / 2) @(posedge clock);
				pin_rd(p);
				`CHK("early timeout", 1'b0, p)
			end
			repeat (n / 2 + 3 * UPD) @(posedge clock);
			pin_rd(p);
			`CHK("timeout", 1'b1, p)
			dev_rd(ADDR_CTRL, v);
			`CHK("flag", 1'b1, v[0])
			pin_rd(p);
			`CHK("released", 1'b0, p)
		end
		dev_wr(ADDR_SETTING, 4'hA);
		repeat (6 * UPD) @(posedge clock);
		dev_rd(ADDR_CTRL, v);
		repeat (6 * UPD) @(posedge clock);
		`CHK("repeat on wire", 1'b0, bus_if.int_n)
		dev_wr(ADDR_SETTING, 4'h0);
		dev_rd(ADDR_CTRL, v);
		// controller interrupt: mask, raise, clear
		bus_wr(HOST_IRQ_CLEAR, 32'h3);
		bus_wr(HOST_IRQ_ENABLE, 32'h0);
		dev_rd(ADDR_CTRL, v);
		`CHK("masked irq", 1'b0, irq)
		bus_rd(HOST_IRQ_STATUS, r);
		`CHK("done sticky", 1'b1, r[EV_DONE_BIT])
		bus_wr(HOST_IRQ_ENABLE, 32'h1);
		`CHK("irq", 1'b1, irq)
		bus_wr(HOST_IRQ_CLEAR, 32'h1);
		@(posedge clock);
		`CHK("irq cleared", 1'b0, irq)
		// test mode: the pin must show both levels of the oscillator
		dev_wr(ADDR_CTRL, 4'h8);
		seen = 2'b00;
		n = 0;
		repeat (700) begin
			@(posedge clock);
			if (update === 1'b1) n++;
			if (bus_if.int_n === 1'b0) seen[0] = 1'b1;
			else if (bus_if.int_n === 1'b1) seen[1] = 1'b1;
		end
		`CHK("oscillator on pin", 2'b11, seen)
		`CHK("update pulses", 35, n)
		bus_rd(HOST_IRQ_STATUS, r);
		`CHK("pin event", 1'b1, r[EV_PIN_BIT])
		dev_wr(ADDR_CTRL, 4'h0);
		tally_and_finish;
	end
endmodule // bcd_timekeeper_bus_clock_tb

//--- tb/rtc_bus_properties.sv
// bus-level assertions between the timekeeper end and the host end
`timescale 1ns/100ps
module rtc_bus_properties
	import rtc_pkg::*;
(
	input wire logic CLOCK_IN,
	input wire logic RESET_N_IN,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic [3:0] addr,
	input wire logic [3:0] data,
	input wire logic dev_data_oe,
	input wire logic int_oe
);
	logic fetch;
	logic store;
	logic store_q;
	logic [3:0] addr_q;
	logic [3:0] data_q;
	logic halt_q;
	logic test_q;

	assign fetch = !cs_n && !rd_n;
	assign store = !cs_n && !wr_n;

	// shadow of halt and test, taken when a store strobe to control ends
	always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			store_q <= 1'b0;
			addr_q <= 4'h0;
			data_q <= 4'h0;
			halt_q <= 1'b0;
			test_q <= 1'b0;
		end else begin
			store_q <= store;
			if (store) begin
				addr_q <= addr;
				data_q <= data;
			end
			if (store_q && !store && addr_q == ADDR_CTRL) begin
				halt_q <= data_q[CTRL_HALT_BIT];
				test_q <= data_q[CTRL_TEST_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (!RESET_N_IN);

	fetch_drive_a: assert property (dev_data_oe |-> $past(fetch))
		else $error("data bus driven outside a read strobe");
	fetch_answer_a: assert property (fetch [*2] |-> dev_data_oe)
		else $error("read strobe left unanswered");
	store_quiet_a: assert property ($past(store) |-> !dev_data_oe)
		else $error("device drove the bus during a write strobe");
	bcd_digit_a: assert property (dev_data_oe && $past(addr) inside {[4'h1:4'hE]}
		|-> data <= DIGIT_MAX)
		else $error("counter digit beyond nine");
	unused_zero_a: assert property (dev_data_oe && $past(addr) inside {[4'h2:4'hE]}
		|-> (data & ~WRITE_MASKS[$past(addr)]) == 4'h0)
		else $error("unused bit read as one");
	halt_tenths_a: assert property (dev_data_oe && halt_q && $past(addr) == ADDR_TENTHS
		|-> data == 4'h0)
		else $error("tenths not held at zero while halted");
	int_release_a: assert property ($past(fetch) && !fetch && $past(addr) == ADDR_CTRL
		&& !test_q |-> ##[1:3] !int_oe)
		else $error("interrupt pin not released by control read");
	osc_slow_a: assert property (test_q && $past(test_q) && $changed(int_oe)
		|=> $stable(int_oe) [*8])
		else $error("test output toggles faster than the oscillator");

	cover property (store ##1 !store);
	cover property ($rose(int_oe));
	cover property (fetch && addr == ADDR_CTRL);
endmodule // rtc_bus_properties
